// *** design/phms_mgmt.sv ***
// serial management slave, interrupt status and negotiation register update logic
`timescale 1ns/100ps
`default_nettype none
module phms_mgmt (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    input wire logic [4:0] phy_addr_i,
    input wire logic [15:0] event_i,
    input wire logic link_up_i,
    input wire logic ability_enter_i,
    input wire logic np_enter_i,
    input wire logic page_rx_i,
    input wire logic page_next_i,
    input wire logic [15:0] page_i,
    input wire logic partner_no_aneg_i,
    input wire logic pd_speed_i,
    input wire logic led2_normal_i,
    output logic indicator_pin_two_o,
    output logic an_start_o,
    output phms_pkg::phms_ctrl_s eff_ctrl_o,
    output logic [15:0] adv_latched_o,
    output logic [15:0] np_latched_o,
    output logic power_down_o,
    output logic res_speed_o,
    output logic res_duplex_o
);
    phms_pkg::phms_state_s st_r;
    phms_pkg::phms_state_s st_nxt;
    logic [6:0] sync_q;
    logic mdc_s;
    logic mdio_s;
    logic [4:0] addr_s;
    logic rise;
    logic ists_clr;
    logic apply;
    logic int_act;
    logic [15:0] wd;

    // register read decode; unmapped addresses read as zero
    function automatic logic [15:0] rd_reg(input phms_pkg::phms_state_s s,
                                           input logic [4:0] a);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            phms_pkg::REG_CTRL: v = s.ctrl;
            phms_pkg::REG_ADV: v = s.adv;
            phms_pkg::REG_LP: v = s.lp;
            phms_pkg::REG_NP: v = s.np;
            phms_pkg::REG_LPNP: v = s.lpnp;
            phms_pkg::REG_SPEC: v = s.spec;
            phms_pkg::REG_IEN: v = s.ien;
            phms_pkg::REG_ISTS: v = s.ists;
            phms_pkg::REG_LED: v = s.led;
            phms_pkg::REG_POL: v = s.pol;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction : rd_reg

    // management clock, data and address straps cross into the core clock
    phms_sync #(.W(7)) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .d_i({mdc_i, mdio_i, phy_addr_i}),
        .q_o(sync_q)
    );
    assign mdc_s = sync_q[6];
    assign mdio_s = sync_q[5];
    assign addr_s = sync_q[4:0];

    // next state of the whole block
    always_comb begin
        st_nxt = st_r;
        st_nxt.an_start = 1'b0;
        ists_clr = 1'b0;
        apply = 1'b0;
        wd = {st_r.sh[14:0], mdio_s};
        rise = mdc_s & ~st_r.mdc_q;
        st_nxt.mdc_q = mdc_s;
        // frame walker, one step per management clock rising edge
        if (rise) begin
            unique case (st_r.fr)
                phms_pkg::FR_IDLE: begin
                    // no preamble needed: first zero is the start bit
                    if (!mdio_s) begin
                        st_nxt.fr = phms_pkg::FR_START;
                    end
                end
                phms_pkg::FR_START: begin
                    if (mdio_s) begin
                        st_nxt.fr = phms_pkg::FR_OP;
                        st_nxt.cnt = 5'h00;
                    end
                end
                phms_pkg::FR_OP: begin
                    st_nxt.op = {st_r.op[0], mdio_s};
                    st_nxt.cnt = st_r.cnt + 5'h01;
                    if (st_r.cnt == phms_pkg::CNT_OP_LAST) begin
                        st_nxt.fr = phms_pkg::FR_PHYAD;
                        st_nxt.cnt = 5'h00;
                    end
                end
                phms_pkg::FR_PHYAD: begin
                    st_nxt.phyad = {st_r.phyad[3:0], mdio_s};
                    st_nxt.cnt = st_r.cnt + 5'h01;
                    if (st_r.cnt == phms_pkg::CNT_ADDR_LAST) begin
                        st_nxt.fr = phms_pkg::FR_REGAD;
                        st_nxt.cnt = 5'h00;
                    end
                end
                phms_pkg::FR_REGAD: begin
                    st_nxt.regad = {st_r.regad[3:0], mdio_s};
                    st_nxt.cnt = st_r.cnt + 5'h01;
                    if (st_r.cnt == phms_pkg::CNT_ADDR_LAST) begin
                        st_nxt.fr = phms_pkg::FR_TA;
                        st_nxt.cnt = 5'h00;
                        st_nxt.hit = (st_r.phyad == addr_s) &&
                                     ((st_r.op == phms_pkg::OP_READ) ||
                                      (st_r.op == phms_pkg::OP_WRITE));
                    end
                end
                phms_pkg::FR_TA: begin
                    st_nxt.cnt = st_r.cnt + 5'h01;
                    if (st_r.hit && st_r.op == phms_pkg::OP_READ) begin
                        if (st_r.cnt == 5'h00) begin
                            // first bit left to the pull-up, then drive zero
                            st_nxt.pin.oe = 1'b1;
                            st_nxt.pin.dout = 1'b0;
                        end else begin
                            st_nxt.sh = rd_reg(st_r, st_r.regad);
                            st_nxt.pin.dout = st_nxt.sh[15];
                            ists_clr = (st_r.regad == phms_pkg::REG_ISTS);
                        end
                    end
                    if (st_r.cnt != 5'h00) begin
                        st_nxt.fr = phms_pkg::FR_DATA;
                        st_nxt.cnt = 5'h00;
                    end
                end
                phms_pkg::FR_DATA: begin
                    st_nxt.cnt = st_r.cnt + 5'h01;
                    if (st_r.op == phms_pkg::OP_READ) begin
                        // most significant bit first
                        st_nxt.sh = {st_r.sh[14:0], 1'b0};
                        st_nxt.pin.dout = st_r.sh[14];
                    end else begin
                        st_nxt.sh = wd;
                    end
                    if (st_r.cnt == phms_pkg::CNT_DATA_LAST) begin
                        st_nxt.fr = phms_pkg::FR_IDLE;
                        st_nxt.pin.oe = 1'b0;
                        st_nxt.pin.dout = 1'b0;
                        // write takes effect at the sixteenth data bit
                        if (st_r.hit && st_r.op == phms_pkg::OP_WRITE) begin
                            unique case (st_r.regad)
                                phms_pkg::REG_CTRL: begin
                                    st_nxt.ctrl = wd & phms_pkg::CTRL_WMASK;
                                    st_nxt.ctrl[phms_pkg::B_SWRST] = 1'b0;
                                    st_nxt.ctrl[phms_pkg::B_RESTART] = 1'b0;
                                    // staged bits go live on these events and on a link drop
                                    apply = wd[phms_pkg::B_SWRST] |
                                            wd[phms_pkg::B_RESTART] |
                                            (st_r.ctrl[phms_pkg::B_PDN] &
                                             ~wd[phms_pkg::B_PDN]);
                                end
                                phms_pkg::REG_ADV: st_nxt.adv = wd;
                                phms_pkg::REG_NP: st_nxt.np = wd;
                                phms_pkg::REG_SPEC: st_nxt.spec = wd;
                                phms_pkg::REG_IEN: st_nxt.ien = wd & phms_pkg::IEN_MASK;
                                phms_pkg::REG_LED: st_nxt.led = wd;
                                phms_pkg::REG_POL: st_nxt.pol = wd;
                                default: st_nxt.hit = 1'b0;
                            endcase
                        end
                    end
                end
                default: st_nxt.fr = phms_pkg::FR_IDLE;
            endcase
        end
        // a drop of the link also brings staged control bits in force
        st_nxt.link_q = link_up_i;
        if (st_r.link_q && !link_up_i) begin
            apply = 1'b1;
        end
        // first cycle after any hardware reset starts negotiation
        if (!st_r.started) begin
            st_nxt.started = 1'b1;
            st_nxt.an_start = 1'b1;
        end
        if (apply) begin
            st_nxt.eff.aneg_en = st_nxt.ctrl[phms_pkg::B_ANEN];
            st_nxt.eff.speed = st_nxt.ctrl[phms_pkg::B_SPEED];
            st_nxt.eff.duplex = st_nxt.ctrl[phms_pkg::B_DUPLEX];
            st_nxt.an_start = 1'b1;
        end
        // sticky status, a new event beats a clear in the same cycle
        st_nxt.ists = (st_r.ists & ~{16{ists_clr}}) | (event_i & phms_pkg::IEN_MASK);
        // advertisement and next page copies for the arbiter
        if (ability_enter_i) begin
            st_nxt.adv_lat = st_r.adv;
        end
        if (np_enter_i) begin
            st_nxt.np_lat = st_r.np;
        end
        // received page storage
        if (page_rx_i) begin
            if (page_next_i && st_r.spec[phms_pkg::B_NP_REDIR]) begin
                st_nxt.lpnp = page_i;
            end else begin
                st_nxt.lp = page_i;
            end
        end
        // parallel detection fixes half duplex
        st_nxt.res_speed = partner_no_aneg_i ? pd_speed_i : st_nxt.eff.speed;
        st_nxt.res_duplex = partner_no_aneg_i ? 1'b0 : st_nxt.eff.duplex;
        // interrupt onto indicator pin two, else its normal indication
        int_act = |(st_nxt.ists & st_nxt.ien);
        if (st_nxt.led[phms_pkg::LED_FN_HI:phms_pkg::LED_FN_LO] == phms_pkg::LED_FN_INT) begin
            st_nxt.ind = st_nxt.pol[phms_pkg::B_POL] ? int_act : ~int_act;
        end else begin
            st_nxt.ind = led2_normal_i;
        end
    end

    // state register; clock enable freezes everything
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '0;
            st_r.fr <= phms_pkg::FR_IDLE;
            st_r.ctrl <= phms_pkg::CTRL_RST;
            st_r.eff.aneg_en <= phms_pkg::CTRL_RST[phms_pkg::B_ANEN];
            st_r.eff.speed <= phms_pkg::CTRL_RST[phms_pkg::B_SPEED];
            st_r.eff.duplex <= phms_pkg::CTRL_RST[phms_pkg::B_DUPLEX];
            st_r.ind <= 1'b1;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign mdio_o = st_r.pin.dout;
    assign mdio_oe_o = st_r.pin.oe;
    assign indicator_pin_two_o = st_r.ind;
    assign an_start_o = st_r.an_start;
    assign eff_ctrl_o = st_r.eff;
    assign adv_latched_o = st_r.adv_lat;
    assign np_latched_o = st_r.np_lat;
    assign power_down_o = st_r.ctrl[phms_pkg::B_PDN];
    assign res_speed_o = st_r.res_speed;
    assign res_duplex_o = st_r.res_duplex;

    // checks on the block's own behaviour
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    AST_STATUS_STICKY: assert property (!ists_clr |=>
        ((st_r.ists & $past(st_r.ists)) == $past(st_r.ists)))
        else $error("status bit lost without a read");
    AST_EVENT_SETS: assert property (ce_i && (event_i != 16'h0000) |=>
        ((st_r.ists & $past(event_i & phms_pkg::IEN_MASK)) ==
         $past(event_i & phms_pkg::IEN_MASK)))
        else $error("event did not set its status bit");
    AST_CLEAR_RACE: assert property (ce_i && ists_clr && (event_i != 16'h0000) |=>
        ((st_r.ists & $past(event_i & phms_pkg::IEN_MASK)) ==
         $past(event_i & phms_pkg::IEN_MASK)))
        else $error("event lost in a clearing read");
    AST_IND_INT: assert property (ce_i &&
        (st_nxt.led[phms_pkg::LED_FN_HI:phms_pkg::LED_FN_LO] == phms_pkg::LED_FN_INT) &&
        ((st_nxt.ists & st_nxt.ien) == 16'h0000) |=>
        (indicator_pin_two_o == !st_r.pol[phms_pkg::B_POL]))
        else $error("indicator active without an enabled event");
    AST_TA_ZERO: assert property ($rose(mdio_oe_o) |-> !mdio_o ##1 mdio_oe_o)
        else $error("read turnaround did not drive zero");
    AST_NO_DRIVE_WRITE: assert property ((st_r.op == 2'h1) &&
        (st_r.fr == phms_pkg::FR_DATA) |-> !mdio_oe_o)
        else $error("pin driven during a write frame");
    AST_ADV_SNAP: assert property (ce_i && ability_enter_i |=>
        adv_latched_o == $past(st_r.adv))
        else $error("advertisement snapshot wrong");
    AST_NP_SNAP: assert property (ce_i && np_enter_i |=> np_latched_o == $past(st_r.np))
        else $error("next page snapshot wrong");
    AST_EFF_HOLD: assert property (ce_i && !apply |=> $stable(eff_ctrl_o))
        else $error("control bits changed without a trigger");
    AST_LINK_DROP: assert property (ce_i && st_r.link_q && !link_up_i |=> an_start_o)
        else $error("link drop did not restart negotiation");
    AST_PAR_HALF: assert property (ce_i && partner_no_aneg_i |=> !res_duplex_o)
        else $error("parallel detection not half duplex");

    // indicator pin follows the enabled status at the chosen level, else its normal source
    AST_IND_ACT: assert property (ce_i &&
        (st_nxt.led[phms_pkg::LED_FN_HI:phms_pkg::LED_FN_LO] == phms_pkg::LED_FN_INT) &&
        ((st_nxt.ists & st_nxt.ien) != 16'h0000) |=>
        (indicator_pin_two_o == st_r.pol[phms_pkg::B_POL]))
        else $error("indicator not active with an enabled event");
    AST_IND_NORMAL: assert property (ce_i &&
        (st_nxt.led[phms_pkg::LED_FN_HI:phms_pkg::LED_FN_LO] != phms_pkg::LED_FN_INT) |=>
        (indicator_pin_two_o == $past(led2_normal_i)))
        else $error("indicator pin lost its normal indication");

    // a status read leaves only the events of its own cycle; unimplemented enable bits never stored
    AST_READ_CLEAR: assert property (ce_i && ists_clr |=>
        ((st_r.ists & ~$past(event_i & phms_pkg::IEN_MASK)) == 16'h0000))
        else $error("status read did not clear");
    AST_IEN_MASK: assert property ((st_r.ien & ~phms_pkg::IEN_MASK) == 16'h0000)
        else $error("unimplemented enable bit set");

    // data pin released outside a matching read
    AST_IDLE_RELEASED: assert property ((st_r.fr == phms_pkg::FR_IDLE) |-> !mdio_oe_o)
        else $error("pin driven while idle");
    AST_NO_HIT_DATA: assert property (!st_r.hit && (st_r.fr == phms_pkg::FR_DATA) |->
        !mdio_oe_o)
        else $error("pin driven for a refused frame");

    // negotiation start after reset, and power-down held until a write clears it
    AST_AN_RESET: assert property (ce_i && !st_r.started |=> an_start_o)
        else $error("no negotiation start after reset");
    AST_PDN_HOLD: assert property (ce_i && st_r.ctrl[phms_pkg::B_PDN] &&
        !(rise && (st_r.fr == phms_pkg::FR_DATA)) |=> power_down_o)
        else $error("power-down left without a write");

    CVR_READ_STATUS: cover property (ists_clr ##1 ce_i);
    CVR_WRITE_CTRL: cover property (apply && rise);
    CVR_IND_ON: cover property ((st_r.led[11:8] == 4'he) && (st_r.ists & st_r.ien) != 16'h0000);
    CVR_NP_REDIR: cover property (page_rx_i && page_next_i && st_r.spec[12]);
    CVR_LINK_DROP: cover property (st_r.link_q && !link_up_i);
endmodule : phms_mgmt
`default_nettype wire

// *** design/phms_pkg.sv ***
// package: register map, field positions, frame states and carriers of the management block
package phms_pkg;

    // register addresses on the serial management bus
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_ADV = 5'h04;
    localparam logic [4:0] REG_LP = 5'h05;
    localparam logic [4:0] REG_NP = 5'h07;
    localparam logic [4:0] REG_LPNP = 5'h08;
    localparam logic [4:0] REG_SPEC = 5'h10;
    localparam logic [4:0] REG_IEN = 5'h12;
    localparam logic [4:0] REG_ISTS = 5'h13;
    localparam logic [4:0] REG_LED = 5'h16;
    localparam logic [4:0] REG_POL = 5'h19;

    // control register fields
    localparam int B_SWRST = 15;
    localparam int B_SPEED = 13;
    localparam int B_ANEN = 12;
    localparam int B_PDN = 11;
    localparam int B_RESTART = 9;
    localparam int B_DUPLEX = 8;
    // specific control: received next pages go to the partner next page register
    localparam int B_NP_REDIR = 12;
    // interrupt polarity, 1 = active high
    localparam int B_POL = 14;
    // indicator function field of the indicator control register
    localparam int LED_FN_LO = 8;
    localparam int LED_FN_HI = 11;
    localparam logic [3:0] LED_FN_INT = 4'he;

    // implemented enable and status bits: 14..6, 4, 1, 0
    localparam logic [15:0] IEN_MASK = 16'h7fd3;
    localparam logic [15:0] CTRL_WMASK = 16'hbb00;
    localparam logic [15:0] CTRL_RST = 16'h3100;

    // frame fields
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [4:0] CNT_OP_LAST = 5'h01;
    localparam logic [4:0] CNT_ADDR_LAST = 5'h04;
    localparam logic [4:0] CNT_DATA_LAST = 5'h0f;

    // management clock ceiling; at 250 MHz a half period is at least 15 cycles
    localparam int MDC_MAX_KHZ = 8330;
    localparam int CLK_KHZ = 250000;
    localparam int MDC_MIN_HALF_CYC = CLK_KHZ / (2 * MDC_MAX_KHZ);

    typedef enum logic [2:0] {
        FR_IDLE,
        FR_START,
        FR_OP,
        FR_PHYAD,
        FR_REGAD,
        FR_TA,
        FR_DATA
    } phms_frame_e;

    // control bits currently in force
    typedef struct packed {
        logic aneg_en;
        logic speed;
        logic duplex;
    } phms_ctrl_s;

    // drive value and output enable of the management data pin
    typedef struct packed {
        logic dout;
        logic oe;
    } phms_pin_s;

    typedef struct packed {
        phms_frame_e fr;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic [1:0] op;
        logic [4:0] phyad;
        logic [4:0] regad;
        logic hit;
        logic mdc_q;
        phms_pin_s pin;
        logic [15:0] ctrl;
        logic [15:0] adv;
        logic [15:0] lp;
        logic [15:0] np;
        logic [15:0] lpnp;
        logic [15:0] spec;
        logic [15:0] ien;
        logic [15:0] ists;
        logic [15:0] led;
        logic [15:0] pol;
        phms_ctrl_s eff;
        logic [15:0] adv_lat;
        logic [15:0] np_lat;
        logic ind;
        logic an_start;
        logic started;
        logic link_q;
        logic res_speed;
        logic res_duplex;
    } phms_state_s;

endpackage : phms_pkg

// *** design/phms_sync.sv ***
// two-flop synchroniser for pins that come from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module phms_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // one pair of flops per bit; the first flop feeds only the second
    for (genvar gi = 0; gi < W; gi++) begin : g_bit
        always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                meta_r[gi] <= 1'b0;
                sync_r[gi] <= 1'b0;
            end else if (ce_i) begin
                meta_r[gi] <= d_i[gi];
                sync_r[gi] <= meta_r[gi];
            end
        end
    end

    assign q_o = sync_r;
endmodule : phms_sync
`default_nettype wire

// *** dv/phms_ctl_model.sv ***
// management controller model: frames on the clock and data pins
`timescale 1ns/100ps
`default_nettype none
module phms_ctl_model #(
    parameter real HALF_NS = 32.0
) (
    input wire logic line_i,
    output logic mdc_o,
    output logic mdio_o,
    output logic mdio_oe_o
);
    // clock stands low and the line is released outside frames
    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
    end
    // one bit: data set while the clock is low, line sampled at the rise
    task automatic bit_io(input logic v, input logic drv, output logic s);
        mdc_o = 1'b0;
        mdio_oe_o = drv;
        mdio_o = v;
        #(HALF_NS);
        mdc_o = 1'b1;
        s = line_i;
        #(HALF_NS);
    endtask : bit_io
    // whole frame without preamble, led by one released idle bit
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
        input logic [15:0] wd, output logic [15:0] rd, output logic ta_ok);
        logic [13:0] hdr;
        logic s;
        logic rdop;
        hdr = {2'b01, op, pa, ra};
        rdop = (op == 2'h2);
        #1.3;
        bit_io(1'b1, 1'b0, s);
        for (int i = 13; i >= 0; i--) bit_io(hdr[i], 1'b1, s);
        bit_io(1'b1, !rdop, s);
        bit_io(1'b0, !rdop, s);
        ta_ok = rdop ? (s === 1'b0) : 1'b1;
        for (int i = 15; i >= 0; i--) begin
            bit_io(wd[i], !rdop, s);
            rd[i] = s;
        end
        mdc_o = 1'b0;
        mdio_oe_o = 1'b0;
    endtask : xfer
endmodule : phms_ctl_model
`default_nettype wire

// *** dv/phms_mgmt_tb.sv ***
// testbench of the management block with a controller model
`timescale 1ns/100ps
`default_nettype none
module phms_mgmt_tb;
    localparam logic [4:0] PA = 5'h0c;
    logic clk_i, nrst_i, mdc, mdo, moe, c_do, c_oe, line;
    logic link_up_i, ab_i, np_i, prx_i, pnx_i, pna_i, pds_i, led_i;
    logic pin, an, pdn, rs, rdup, ce;
    logic [15:0] event_i, page_i, adv_l, np_l;
    phms_pkg::phms_ctrl_s eff;
    int n_errors = 0;
    int check_count = 0;
    int an_n = 0;
    // wire with pull-up, device drive wins over released controller
    assign line = moe ? mdo : (c_oe ? c_do : 1'b1);
    phms_mgmt phms_mgmt_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce), .mdc_i(mdc),
        .mdio_i(line), .mdio_o(mdo), .mdio_oe_o(moe), .phy_addr_i(PA), .event_i(event_i),
        .link_up_i(link_up_i), .ability_enter_i(ab_i), .np_enter_i(np_i), .page_rx_i(prx_i),
        .page_next_i(pnx_i), .page_i(page_i), .partner_no_aneg_i(pna_i), .pd_speed_i(pds_i),
        .led2_normal_i(led_i), .indicator_pin_two_o(pin), .an_start_o(an), .eff_ctrl_o(eff),
        .adv_latched_o(adv_l), .np_latched_o(np_l), .power_down_o(pdn), .res_speed_o(rs),
        .res_duplex_o(rdup));
    phms_ctl_model ctl_i (.line_i(line), .mdc_o(mdc), .mdio_o(c_do), .mdio_oe_o(c_oe));
    // count negotiation start pulses, looked at away from the launching edge
    always @(negedge clk_i) begin
        if (an === 1'b1) an_n++;
    end
    task automatic final_report();
        if (n_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask : w
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] r;
        logic t;
        ctl_i.xfer(phms_pkg::OP_WRITE, PA, ra, d, r, t);
        w(4);
    endtask : wr
    task automatic rdc(input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] r;
        logic t;
        ctl_i.xfer(phms_pkg::OP_READ, PA, ra, 16'h0, r, t);
        chk({15'h0, t}, 16'h1);
        chk(r, exp);
        w(4);
    endtask : rdc
    task automatic ev(input logic [15:0] e);
        @(posedge clk_i);
        event_i <= e;
        @(posedge clk_i);
        event_i <= 16'h0;
        w(3);
    endtask : ev
    // enable register mask, refused frames and an unmapped read
    task automatic t_reg();
        logic [15:0] r;
        logic t;
        wr(phms_pkg::REG_IEN, 16'hffff);
        rdc(phms_pkg::REG_IEN, 16'h7fd3);
        ctl_i.xfer(phms_pkg::OP_WRITE, 5'h03, phms_pkg::REG_IEN, 16'h0, r, t);
        ctl_i.xfer(2'h0, PA, phms_pkg::REG_IEN, 16'h0, r, t);
        rdc(phms_pkg::REG_IEN, 16'h7fd3);
        rdc(5'h1f, 16'h0000);
        wr(phms_pkg::REG_IEN, 16'h0000);
    endtask : t_reg
    // sticky status, masking, polarity and routing to the indicator pin
    task automatic t_irq();
        chk({15'h0, pin}, 16'h1);
        wr(phms_pkg::REG_LED, 16'h0e00);
        ev(16'hffff);
        chk({15'h0, pin}, 16'h1);
        rdc(phms_pkg::REG_ISTS, 16'h7fd3);
        rdc(phms_pkg::REG_ISTS, 16'h0000);
        wr(phms_pkg::REG_IEN, 16'h0001);
        ev(16'h0001);
        chk({15'h0, pin}, 16'h0);
        wr(phms_pkg::REG_POL, 16'h4000);
        chk({15'h0, pin}, 16'h1);
        rdc(phms_pkg::REG_ISTS, 16'h0001);
        chk({15'h0, pin}, 16'h0);
        ev(16'h0001);
        chk({15'h0, pin}, 16'h1);
        wr(phms_pkg::REG_IEN, 16'h0000);
        chk({15'h0, pin}, 16'h0);
        event_i <= 16'h0002;
        rdc(phms_pkg::REG_ISTS, 16'h0003);
        event_i <= 16'h0000;
        rdc(phms_pkg::REG_ISTS, 16'h0002);
        wr(phms_pkg::REG_LED, 16'h0000);
        led_i <= 1'b0;
        w(3);
        chk({15'h0, pin}, 16'h0);
        // a frozen block must not record an event
        ce <= 1'b0;
        ev(16'h0001);
        ce <= 1'b1;
        rdc(phms_pkg::REG_ISTS, 16'h0000);
    endtask : t_irq
    // control bits apply only on restart, link drop, power-down exit, soft reset
    task automatic t_ctrl();
        chk(an_n[15:0], 16'h1);
        chk({13'h0, eff}, 16'h7);
        wr(phms_pkg::REG_CTRL, 16'h2000);
        chk({13'h0, eff}, 16'h7);
        wr(phms_pkg::REG_CTRL, 16'h0300);
        chk({13'h0, eff}, 16'h1);
        rdc(phms_pkg::REG_CTRL, 16'h0100);
        wr(phms_pkg::REG_CTRL, 16'h3100);
        link_up_i <= 1'b0;
        w(3);
        chk({13'h0, eff}, 16'h7);
        link_up_i <= 1'b1;
        wr(phms_pkg::REG_CTRL, 16'h0800);
        chk({15'h0, pdn}, 16'h1);
        rdc(phms_pkg::REG_CTRL, 16'h0800);
        chk({13'h0, eff}, 16'h7);
        wr(phms_pkg::REG_CTRL, 16'h2000);
        chk({15'h0, pdn}, 16'h0);
        chk({13'h0, eff}, 16'h2);
        wr(phms_pkg::REG_CTRL, 16'hb100);
        chk({13'h0, eff}, 16'h7);
        chk(an_n[15:0], 16'h5);
    endtask : t_ctrl
    // advertisement and next page snapshots
    task automatic t_snap();
        wr(phms_pkg::REG_ADV, 16'h01e1);
        @(posedge clk_i);
        ab_i <= 1'b1;
        @(posedge clk_i);
        ab_i <= 1'b0;
        wr(phms_pkg::REG_ADV, 16'h0021);
        chk(adv_l, 16'h01e1);
        wr(phms_pkg::REG_NP, 16'h2001);
        @(posedge clk_i);
        np_i <= 1'b1;
        @(posedge clk_i);
        np_i <= 1'b0;
        w(2);
        chk(np_l, 16'h2001);
    endtask : t_snap
    task automatic pg(input logic [15:0] d, input logic nx);
        @(posedge clk_i);
        page_i <= d;
        pnx_i <= nx;
        prx_i <= 1'b1;
        @(posedge clk_i);
        prx_i <= 1'b0;
        w(2);
    endtask : pg
    // page storage, redirect of next pages, parallel detection
    task automatic t_page();
        pg(16'h4de1, 1'b0);
        rdc(phms_pkg::REG_LP, 16'h4de1);
        pg(16'h2002, 1'b1);
        rdc(phms_pkg::REG_LP, 16'h2002);
        wr(phms_pkg::REG_SPEC, 16'h1000);
        pg(16'h2003, 1'b1);
        wr(phms_pkg::REG_LP, 16'hffff);
        rdc(phms_pkg::REG_LP, 16'h2002);
        rdc(phms_pkg::REG_LPNP, 16'h2003);
        chk({14'h0, rs, rdup}, 16'h3);
        pna_i <= 1'b1;
        w(3);
        chk({14'h0, rs, rdup}, 16'h0);
        pds_i <= 1'b1;
        w(3);
        chk({14'h0, rs, rdup}, 16'h2);
    endtask : t_page
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // watchdog against a hung frame, about 50000 cycles, well past the run's length
    initial begin
        #200000;
        n_errors++;
        final_report();
    end
    initial begin
        {nrst_i, ab_i, np_i, prx_i, pnx_i, pna_i, pds_i} = 7'h0;
        {link_up_i, led_i} = 2'h3;
        ce = 1'b1;
        event_i = 16'h0;
        page_i = 16'h0;
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        w(4);
        t_ctrl();
        t_reg();
        t_irq();
        t_snap();
        t_page();
        final_report();
    end
endmodule : phms_mgmt_tb
`default_nettype wire
